// [rtl/dcff_top.sv]
// dual clock field fifo: 256K x 8 field store with staging rows and a static head buffer
`timescale 1ns/1ps
`default_nettype none
`include "dcff_regs.svh"
module dcff_top
	import dcff_pkg::*;
(
	// system clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// input side pins
	input  wire logic             i_input_side_clock,
	input  wire logic [7:0]       i_write_data_in,
	input  wire logic             i_input_accept_gate_n,
	input  wire logic             i_input_pointer_reset_n,
	// output side pins
	input  wire logic             i_output_side_clock,
	input  wire logic             i_output_advance_gate_n,
	input  wire logic             i_output_pointer_reset_n,
	input  wire logic             i_output_enable_n,
	output logic      [7:0]       o_read_data_out,
	output logic                  o_read_data_out_oe,
	// status
	output logic                  o_write_overflow
);
	localparam int PW = $bits(dcff_pins_s);
	localparam int IW = $bits(dcff_witem_s);
	localparam int REF_W = `DCFF_REFRESH_W;
	// last timer count of a refresh period
	localparam logic [REF_W-1:0] REF_LAST = REF_W'(`DCFF_REFRESH_CYC - 1);

	dcff_state_s                st;
	dcff_state_s                next_st;
	dcff_pins_s                 pins;
	logic [PW-1:0]              raw;
	logic [PW-1:0]              sync1;
	logic [PW-1:0]              sync2;
	logic [`DCFF_ROW_BITS-1:0]  array [`DCFF_ROWS];
	logic [`DCFF_ROW_BITS-1:0]  rstage;
	logic                       wedge;
	logic                       redge;
	logic                       fifo_push;
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	dcff_witem_s                fifo_out;
	logic                       drain;
	logic                       mem_we;
	logic [`DCFF_ROW_W-1:0]     mem_wrow;
	logic [`DCFF_ROW_BITS-1:0]  mem_wdata;
	logic                       rload;
	logic [`DCFF_ROW_W-1:0]     rload_row;
	logic                       rrestart;
	dcff_byte_t                 rbyte;

	assign raw = {i_input_side_clock, i_write_data_in, i_input_accept_gate_n,
		i_input_pointer_reset_n, i_output_side_clock, i_output_advance_gate_n,
		i_output_pointer_reset_n, i_output_enable_n};

	// every pin is asynchronous to i_clk, so each bit passes two flops
	for (genvar g = 0; g < PW; g++) begin : g_sync
		always_ff @(posedge i_clk) begin
			sync1[g] <= raw[g];
			sync2[g] <= sync1[g];
		end
	end
	assign pins = dcff_pins_s'(sync2);

	// pin clocks are sampled, so they must run below a quarter of i_clk
	assign wedge = pins.wclk & ~st.wclk_d;
	assign redge = pins.rclk & ~st.rclk_d;

	// the edge that closes a write cycle pushes its byte, if the cycle was enabled
	assign fifo_push = wedge & st.wcyc_open & st.wcyc_en;

	// single-port array: a row load takes the port, the drain waits a cycle
	assign drain = fifo_out_valid & ~rload;

	dcff_fifo #(
		.WIDTH(IW),
		.DEPTH(`DCFF_FIFO_DEPTH)
	) u_wfifo (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_in_valid (fifo_push),
		.i_in_data  ({st.wcyc_restart, pins.wdata}),
		.o_in_ready (fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data (fifo_out),
		.i_out_ready(drain)
	);

	always_comb begin
		logic [`DCFF_COL_W-1:0]        col;
		logic [`DCFF_ROW_W-1:0]        row;
		logic [`DCFF_STATIC_CNT_W-1:0] scnt;
		logic                          input_pointer_reset_n;
		col       = '0;
		row       = '0;
		scnt      = '0;
		input_pointer_reset_n      = 1'b0;
		next_st   = st;
		mem_we    = 1'b0;
		mem_wrow  = '0;
		mem_wdata = '0;
		rload     = 1'b0;
		rload_row = '0;
		rrestart  = 1'b0;
		rbyte     = '0;
		next_st.wclk_d = pins.wclk;
		next_st.rclk_d = pins.rclk;
		next_st.wfull  = fifo_push & ~fifo_in_ready;

		// write side: open the next cycle on each input clock edge
		if (wedge) begin
			input_pointer_reset_n = ~pins.input_pointer_reset_n_n | st.wpend;
			next_st.wcyc_open = 1'b1;
			next_st.wcyc_en   = ~pins.wgate_n;
			if (!pins.wgate_n) begin
				next_st.wcyc_restart = input_pointer_reset_n;
				next_st.wpend        = 1'b0;
			end else begin
				next_st.wcyc_restart = 1'b0;
				next_st.wpend        = input_pointer_reset_n;
			end
		end

		// store one queued byte into staging, and into the static head buffer if it is one of the first 80 after a restart
		if (drain) begin
			col  = fifo_out.restart ? '0 : st.wcol;
			row  = fifo_out.restart ? '0 : st.wrow;
			scnt = fifo_out.restart ? '0 : st.wscnt;
			next_st.wstage[32'(col) * 8 +: 8] = fifo_out.data;
			if (scnt < `DCFF_STATIC_WORDS) begin
				next_st.sbuf[32'(scnt) * 8 +: 8] = fifo_out.data;
				scnt = 7'(scnt + 7'h1);
			end
			next_st.wscnt = scnt;
			if (col == `DCFF_COL_LAST) begin
				mem_we      = 1'b1;
				mem_wrow    = row;
				mem_wdata   = next_st.wstage;
				next_st.wcol = '0;
				next_st.wrow = (row == `DCFF_ROW_LAST) ? '0 : 12'(row + 12'h1);
			end else begin
				next_st.wcol = 6'(col + 6'h1);
				next_st.wrow = row;
			end
		end

		// read side: decide this cycle's byte on the edge that starts it
		if (redge) begin
			rrestart = ~pins.rgate_n & (~pins.output_pointer_reset_n_n | st.rpend);
			next_st.rpend = pins.rgate_n & (~pins.output_pointer_reset_n_n | st.rpend);
			col  = rrestart ? '0 : st.rcol;
			row  = rrestart ? '0 : st.rrow;
			scnt = rrestart ? '0 : st.rscnt;
			if (scnt < `DCFF_STATIC_WORDS) begin
				rbyte = st.sbuf[32'(scnt) * 8 +: 8];
			end else begin
				rbyte = rstage[32'(col) * 8 +: 8];
			end
			next_st.rdata = rbyte;
			next_st.roe   = ~pins.oe_n;
			// the pointer moves whatever the output enable says
			if (!pins.rgate_n) begin
				if (scnt < `DCFF_STATIC_WORDS) begin
					scnt = 7'(scnt + 7'h1);
				end
				if (col == `DCFF_COL_LAST) begin
					rload     = 1'b1;
					rload_row = (row == `DCFF_ROW_LAST) ? '0 : 12'(row + 12'h1);
					next_st.rcol = '0;
					next_st.rrow = rload_row;
				end else begin
					next_st.rcol = 6'(col + 6'h1);
					next_st.rrow = row;
				end
				next_st.rscnt = scnt;
			end // gate high leaves pointer as is
		end

		// self refresh: a row per timer period, no outside action needed
		if (st.ref_timer == REF_LAST) begin
			next_st.ref_timer = '0;
			next_st.ref_row   = 12'(st.ref_row + 12'h1);
		end else begin
			next_st.ref_timer = REF_W'(st.ref_timer + 1'b1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// the field array: one row of 64 bytes per access
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			array[mem_wrow] <= mem_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rstage <= '0;
		end else if (rload) begin
			rstage <= array[rload_row];
		end
	end

	// outputs, all registered; sides share only the array and static buffer
	assign o_read_data_out    = st.rdata;
	assign o_read_data_out_oe = st.roe;
	assign o_write_overflow   = st.wfull;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_gated_read_reset;
		redge && pins.rgate_n && !pins.output_pointer_reset_n_n;
	endsequence

	sequence s_enabled_read;
		redge && !pins.rgate_n;
	endsequence

	chk_oe_float: assert property (redge && pins.oe_n |=> !o_read_data_out_oe)
		else $error("data outputs driven while enable high");
	chk_oe_drive: assert property (redge && !pins.oe_n |=> o_read_data_out_oe)
		else $error("data outputs not driven while enable low");
	sequence s_read_step;
		s_enabled_read ##0 !rrestart && st.rcol != `DCFF_COL_LAST;
	endsequence

	sequence s_write_step;
		drain && !fifo_out.restart && st.wcol != `DCFF_COL_LAST;
	endsequence

	// an empty queue must stay empty when a gated write cycle closes
	sequence s_gated_write_close;
		wedge && st.wcyc_open && !st.wcyc_en && !fifo_out_valid;
	endsequence

	chk_read_hold: assert property (redge && pins.rgate_n |=>
		$stable(st.rcol) && $stable(st.rrow))
		else $error("read pointer moved while gated");
	chk_read_step: assert property (s_read_step |=> st.rcol == 6'($past(st.rcol) + 6'h1))
		else $error("read pointer failed to advance");
	chk_read_reset: assert property (s_enabled_read ##0 !pins.output_pointer_reset_n_n |=>
		st.rcol == 6'h1 && st.rrow == '0 && st.rscnt == 7'h1)
		else $error("read reset did not restart address");
	chk_pend_reset: assert property (s_gated_read_reset |=> st.rpend
		##0 (st.rcol == $past(st.rcol)))
		else $error("gated read reset not held back");
	chk_pend_apply: assert property (s_enabled_read ##0 st.rpend |=>
		st.rcol == 6'h1 && st.rrow == '0)
		else $error("pending read reset not applied");
	chk_write_gate: assert property (s_gated_write_close |=> !fifo_out_valid)
		else $error("byte queued from a gated write cycle");
	chk_stage_burst: assert property (mem_we |=> st.wcol == '0 &&
		st.wrow == 12'($past(mem_wrow) + 12'h1))
		else $error("staging burst left pointers wrong");
	chk_static_read: assert property (s_enabled_read ##0 rrestart |=>
		o_read_data_out == st.sbuf[7:0] || $past(drain))
		else $error("first word after reset not from static buffer");
	chk_refresh_tick: assert property (st.ref_timer == REF_LAST |=>
		st.ref_row == 12'($past(st.ref_row) + 12'h1) && st.ref_timer == '0)
		else $error("refresh row did not advance");
	chk_write_restart: assert property (drain && fifo_out.restart |=>
		st.wcol == 6'h1 && st.wrow == '0 && st.wscnt == 7'h1)
		else $error("write reset did not restart address");
	chk_write_step: assert property (s_write_step |=> st.wcol == 6'($past(st.wcol) + 6'h1))
		else $error("write pointer failed to advance");
	chk_write_pend: assert property (wedge && pins.wgate_n && !pins.input_pointer_reset_n_n |=> st.wpend)
		else $error("gated write reset not held back");
endmodule : dcff_top
`default_nettype wire

// [rtl/dcff_regs.svh]
// constants for the dual clock field fifo: geometry, counts and timing
`ifndef DCFF_REGS_SVH
`define DCFF_REGS_SVH
`define DCFF_DATA_W         8
`define DCFF_COL_W          6
`define DCFF_ROW_W          12
`define DCFF_ADDR_W         18
`define DCFF_ROW_WORDS      64
`define DCFF_ROW_BITS       512
`define DCFF_ROWS           4096
`define DCFF_COL_LAST       6'h3f
`define DCFF_ROW_LAST       12'hfff
`define DCFF_STATIC_WORDS   7'h50
`define DCFF_STATIC_BITS    640
`define DCFF_STATIC_CNT_W   7
`define DCFF_FIFO_DEPTH     8
`define DCFF_CLK_PERIOD_NS  20
`define DCFF_REFRESH_NS     15600
`define DCFF_REFRESH_CYC    (`DCFF_REFRESH_NS / `DCFF_CLK_PERIOD_NS)
`define DCFF_REFRESH_W      10
`endif

// [rtl/dcff_pkg.sv]
// types shared by the dual clock field fifo modules
`include "dcff_regs.svh"
package dcff_pkg;
	typedef logic [`DCFF_DATA_W-1:0] dcff_byte_t;

	// one accepted write word, tagged with a pointer restart
	typedef struct packed {
		logic       restart;
		dcff_byte_t data;
	} dcff_witem_s;

	// pin levels after synchronisation
	typedef struct packed {
		logic       wclk;
		dcff_byte_t wdata;
		logic       wgate_n;
		logic       input_pointer_reset_n_n;
		logic       rclk;
		logic       rgate_n;
		logic       output_pointer_reset_n_n;
		logic       oe_n;
	} dcff_pins_s;

	typedef struct packed {
		logic                          wclk_d;
		logic                          rclk_d;
		logic                          wcyc_open;
		logic                          wcyc_en;
		logic                          wcyc_restart;
		logic                          wpend;
		logic [`DCFF_ROW_W-1:0]        wrow;
		logic [`DCFF_COL_W-1:0]        wcol;
		logic [`DCFF_STATIC_CNT_W-1:0] wscnt;
		logic [`DCFF_ROW_BITS-1:0]     wstage;
		logic [`DCFF_STATIC_BITS-1:0]  sbuf;
		logic [`DCFF_ROW_W-1:0]        rrow;
		logic [`DCFF_COL_W-1:0]        rcol;
		logic [`DCFF_STATIC_CNT_W-1:0] rscnt;
		logic                          rpend;
		dcff_byte_t                    rdata;
		logic                          roe;
		logic                          wfull;
		logic [`DCFF_REFRESH_W-1:0]    ref_timer;
		logic [`DCFF_ROW_W-1:0]        ref_row;
	} dcff_state_s;
endpackage : dcff_pkg

// [rtl/dcff_fifo.sv]
// small parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} dcff_fifo_state_s;

	dcff_fifo_state_s st;
	dcff_fifo_state_s next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign o_in_ready  = (st.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (st.cnt != '0);
	assign o_out_data  = mem[st.rp];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : AW'(st.wp + 1'b1);
		end
		if (pop) begin
			next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : AW'(st.rp + 1'b1);
		end
		next_st.cnt = (AW+1)'(st.cnt + {AW'(0), push} - {AW'(0), pop});
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[st.wp] <= i_in_data;
		end
	end
endmodule : dcff_fifo
`default_nettype wire

// [tb/dcff_video_side.sv]
// partner model: video logic clocking bytes into and out of the field fifo pins
`timescale 1ns/1ps
`default_nettype none
module dcff_video_side
	import dcff_pkg::*;
(
	// system clock
	input  wire logic       i_clk,
	// write side pins
	output logic            o_wck,
	output dcff_byte_t      o_wdata,
	output logic            o_wgate_n,
	output logic            o_input_pointer_reset_n_n,
	// read side pins
	output logic            o_rck,
	output logic            o_rgate_n,
	output logic            o_output_pointer_reset_n_n,
	output logic            o_oe_n,
	input  wire dcff_byte_t i_rdata,
	input  wire logic       i_roe
);
	dcff_byte_t held;

	// pin clocks stand still low between cycles
	initial begin
		o_wck     = 1'b0;
		o_wdata   = 8'h00;
		o_wgate_n = 1'b1;
		o_input_pointer_reset_n_n  = 1'b1;
		o_rck     = 1'b0;
		o_rgate_n = 1'b1;
		o_output_pointer_reset_n_n  = 1'b1;
		o_oe_n    = 1'b1;
		held      = 8'h00;
	end

	// a cycle's byte rides on the next cycle's opening edge, so it is held over
	task automatic wcyc(input logic g, input logic r, input dcff_byte_t d);
		@(posedge i_clk);
		o_wdata   <= held;
		o_wgate_n <= g;
		o_input_pointer_reset_n_n  <= r;
		o_wck     <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_wck <= 1'b0;
		@(posedge i_clk);
		// hold time over: show a wrong byte so a late sample cannot match
		o_wdata <= ~held;
		held = d;
		repeat (2) @(posedge i_clk);
	endtask : wcyc

	task automatic rcyc(input logic g, input logic r, input logic oe,
		output dcff_byte_t d, output logic v);
		@(posedge i_clk);
		o_rgate_n <= g;
		o_output_pointer_reset_n_n  <= r;
		o_oe_n    <= oe;
		o_rck     <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_rck <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		d = i_rdata;
		v = i_roe;
	endtask : rcyc
endmodule : dcff_video_side
`default_nettype wire

// [tb/dual_clock_field_fifo_bench.sv]
// testbench for the dual clock field fifo
`timescale 1ns/1ps
`default_nettype none
module dual_clock_field_fifo_bench
	import dcff_pkg::*;
;
	logic       clk;
	logic       rst;
	logic       input_side_clock;
	dcff_byte_t wdata;
	logic       wgate_n;
	logic       input_pointer_reset_n_n;
	logic       output_side_clock;
	logic       rgate_n;
	logic       output_pointer_reset_n_n;
	logic       oe_n;
	dcff_byte_t rdata;
	logic       roe;
	logic       ovf;
	int         err_count;
	int         compares;
	int         cyc;
	dcff_byte_t mem [0:399];

	dcff_top dut (.i_clk(clk), .i_reset(rst), .i_input_side_clock(input_side_clock),
		.i_write_data_in(wdata), .i_input_accept_gate_n(wgate_n),
		.i_input_pointer_reset_n(input_pointer_reset_n_n), .i_output_side_clock(output_side_clock),
		.i_output_advance_gate_n(rgate_n), .i_output_pointer_reset_n(output_pointer_reset_n_n),
		.i_output_enable_n(oe_n), .o_read_data_out(rdata),
		.o_read_data_out_oe(roe), .o_write_overflow(ovf));

	dcff_video_side vs (.i_clk(clk), .o_wck(input_side_clock), .o_wdata(wdata), .o_wgate_n(wgate_n),
		.o_input_pointer_reset_n_n(input_pointer_reset_n_n), .o_rck(output_side_clock), .o_rgate_n(rgate_n), .o_output_pointer_reset_n_n(output_pointer_reset_n_n),
		.o_oe_n(oe_n), .i_rdata(rdata), .i_roe(roe));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// about 13.5k cycles are needed; a hang is cut well above that
	always @(posedge clk) begin
		cyc++;
		if (!rst && ovf !== 1'b0)
			err_count++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic chk(input dcff_byte_t got, input dcff_byte_t exp);
		compares++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask : chk

	function automatic dcff_byte_t pat(input int i, input int s);
		return dcff_byte_t'(i * 5 + s);
	endfunction : pat

	// every gap-th cycle is gated and offers a junk byte
	task automatic wr_run(input int n, input int s, input int gap, input logic r0);
		int k;
		k = 0;
		for (int c = 0; k < n; c++) begin
			if (gap != 0 && c % gap == gap - 1) begin
				vs.wcyc(1'b1, 1'b1, 8'hee);
			end else begin
				mem[k] = pat(k, s);
				vs.wcyc(1'b0, (c == 0) ? r0 : 1'b1, mem[k]);
				k++;
			end
		end
		vs.wcyc(1'b1, 1'b1, 8'h00);
	endtask : wr_run

	task automatic rd_run(input int n, input int gap, input int ogap, input logic r0);
		int         a;
		dcff_byte_t d;
		logic       v;
		logic       g;
		logic       o;
		a = 0;
		for (int c = 0; a < n; c++) begin
			g = gap != 0 && c > 0 && c % gap == gap - 1;
			o = ogap != 0 && c % ogap == ogap - 1;
			vs.rcyc(g, (c == 0) ? r0 : 1'b1, o, d, v);
			chk({7'h00, v}, {7'h00, ~o});
			// a gated cycle shows the word at the held pointer, then repeats it
			if (!o)
				chk(d, mem[a]);
			if (!g)
				a++;
		end
	endtask : rd_run

	task automatic t_init();
		dcff_byte_t d;
		logic       v;
		vs.wcyc(1'b0, 1'b0, 8'h00);
		vs.rcyc(1'b0, 1'b0, 1'b0, d, v);
		for (int i = 0; i < 83; i++) begin
			vs.wcyc(1'b0, 1'b1, 8'h00);
			vs.rcyc(1'b0, 1'b1, 1'b0, d, v);
		end
		$display("test init done");
	endtask : t_init

	task automatic t_stream();
		wr_run(400, 3, 0, 1'b0);
		rd_run(200, 0, 0, 1'b0);
		$display("test stream done");
	endtask : t_stream

	task automatic t_gates();
		wr_run(400, 9, 6, 1'b0);
		rd_run(200, 7, 0, 1'b0);
		$display("test gates done");
	endtask : t_gates

	task automatic t_oe();
		rd_run(150, 0, 4, 1'b0);
		$display("test output enable done");
	endtask : t_oe

	// a reset offered in a gated cycle must land on the next enabled cycle
	task automatic t_pending_reset();
		dcff_byte_t d;
		logic       v;
		vs.wcyc(1'b1, 1'b0, 8'h00);
		wr_run(400, 21, 0, 1'b1);
		rd_run(10, 0, 0, 1'b0);
		vs.rcyc(1'b1, 1'b0, 1'b0, d, v);
		rd_run(200, 0, 0, 1'b1);
		$display("test pending reset done");
	endtask : t_pending_reset

	initial begin
		rst       = 1'b1;
		err_count = 0;
		compares  = 0;
		cyc       = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_init();
		t_stream();
		t_gates();
		t_oe();
		t_pending_reset();
		end_of_test();
	end
endmodule : dual_clock_field_fifo_bench
`default_nettype wire
